/* hdl/adc_cfg_pkg.sv */
// Constants, field positions and types for the converter configuration serial port.
// Assumes a single 25 MHz system clock; all serial pins arrive asynchronously.
package adc_cfg_pkg;

    localparam int ADDR_WIDTH = 13;
    localparam int INSTR_BITS = 16;
    localparam int WORD_BITS = 8;

    // Register offsets
    localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] ADDR_CHIP_ID = 8'h01;
    localparam logic [7:0] ADDR_CHIP_GRADE = 8'h02;
    localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05;
    localparam logic [7:0] ADDR_SHADOW_LO = 8'h08;
    localparam logic [7:0] ADDR_CLOCK_DIVIDE = 8'h0B;
    localparam logic [7:0] ADDR_OUTPUT_FORMAT = 8'h14;
    localparam logic [7:0] ADDR_SHADOW_HI = 8'h20;
    localparam logic [7:0] ADDR_DIVIDER_ALIGN = 8'h3A;
    localparam logic [7:0] ADDR_SHADOW_COMMIT = 8'hFF;
    localparam int SHADOW_DEPTH = 25;

    // Reset values
    localparam logic [7:0] RESET_PORT_CFG = 8'h18;
    localparam logic [7:0] RESET_OUTPUT_FORMAT = 8'h05;
    localparam logic [1:0] RESET_CHAN_INDEX = 2'h3;
    localparam logic [7:0] RESET_ZERO = 8'h00;

    // Field positions and masks
    localparam logic [7:0] PORT_LSB_FIRST_MASK = 8'h42;
    localparam logic [7:0] PORT_SOFT_RESET_MASK = 8'h24;
    localparam int PORT_LSB_FIRST_BIT = 1;
    localparam int CHAN_A_BIT = 0;
    localparam int CHAN_B_BIT = 1;
    localparam int COMMIT_BIT = 0;
    localparam int ALIGN_ENABLE_BIT = 1;
    localparam int ALIGN_ONESHOT_BIT = 2;
    localparam int DIVIDE_RATIO_LSB = 0;
    localparam int DIVIDE_RATIO_MSB = 2;
    localparam int INSTR_RW_BIT = 15;
    localparam int INSTR_LEN_MSB = 14;
    localparam int INSTR_LEN_LSB = 13;
    localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
    localparam logic [2:0] WORD_LAST_BIT = 3'h7;

    // Length field codes
    localparam logic [1:0] LEN_ONE = 2'h0;
    localparam logic [1:0] LEN_TWO = 2'h1;
    localparam logic [1:0] LEN_THREE = 2'h2;
    localparam logic [1:0] LEN_STREAM = 2'h3;

    typedef struct packed {
        logic sclk;
        logic select_low;
        logic sdio;
        logic sync_align;
    } pins_in_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_INSTR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_PAUSE = 4'b1000
    } frame_state_t;

endpackage : adc_cfg_pkg

/* hdl/two_flop_sync.sv */
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are independent levels; no word coherence is given.
`timescale 1ns/1ps
`default_nettype none
module two_flop_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : two_flop_sync
`default_nettype wire

/* hdl/adc_config_serial_port.sv */
// Configuration serial port, shadowed register file and sync-aligned clock divider.
// Assumes serial pins and sync are asynchronous to sys_clk and sys_clk is well
// above four times the serial clock rate.
`timescale 1ns/1ps
`default_nettype none
module adc_config_serial_port #(
    parameter logic [7:0] CHIP_ID = 8'h5A,   // Arbitrary value
    parameter logic [7:0] CHIP_GRADE = 8'h00 // Arbitrary value
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Serial port pins
    input wire logic serial_shift_clock,
    input wire logic select_low,
    input wire logic serial_bidir_data_in,
    output logic serial_bidir_data_out,
    output logic serial_bidir_data_oe,
    output logic secondary_function_enable,
    // Divider sync
    input wire logic sync_align_input,
    output logic divider_tick,
    // Active configuration
    output logic [7:0] output_format_a,
    output logic [7:0] output_format_b,
    output logic [7:0] divider_align_active
);
    adc_cfg_pkg::pins_in_t pins;
    adc_cfg_pkg::frame_state_t state;
    adc_cfg_pkg::frame_state_t resume_state;
    logic sclk_q;
    logic select_q;
    logic sync_q;
    logic sclk_rise;
    logic sclk_fall;
    logic select_fall;
    logic select_rise;
    logic sync_rise;
    logic lsb_first;
    logic [3:0] bit_cnt;
    logic [15:0] instr;
    logic [15:0] next_instr;
    logic [7:0] data_shift;
    logic [7:0] next_data;
    logic [7:0] read_shift;
    logic [adc_cfg_pkg::ADDR_WIDTH-1:0] addr;
    logic is_read;
    logic [1:0] len_code;
    logic [1:0] bytes_done;
    logic wr_en;
    logic [adc_cfg_pkg::ADDR_WIDTH-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] port_cfg;
    logic [1:0] chan_index;
    logic commit;
    logic soft_reset;
    logic [7:0] align_shadow;
    logic [7:0] shadow_a [adc_cfg_pkg::SHADOW_DEPTH];
    logic [7:0] shadow_b [adc_cfg_pkg::SHADOW_DEPTH];
    logic [7:0] active_a [adc_cfg_pkg::SHADOW_DEPTH];
    logic [7:0] active_b [adc_cfg_pkg::SHADOW_DEPTH];
    logic [2:0] div_count;
    logic [2:0] div_ratio;
    logic aligned_once;

    function automatic logic in_shadow(input logic [7:0] a);
        return a >= adc_cfg_pkg::ADDR_SHADOW_LO && a <= adc_cfg_pkg::ADDR_SHADOW_HI;
    endfunction : in_shadow

    function automatic logic [4:0] shadow_index(input logic [7:0] a);
        logic [7:0] diff;
        diff = a - adc_cfg_pkg::ADDR_SHADOW_LO;
        return diff[4:0];
    endfunction : shadow_index

    function automatic logic [7:0] reset_value(input int idx);
        if (idx == int'(adc_cfg_pkg::ADDR_OUTPUT_FORMAT - adc_cfg_pkg::ADDR_SHADOW_LO)) begin
            return adc_cfg_pkg::RESET_OUTPUT_FORMAT;
        end
        return adc_cfg_pkg::RESET_ZERO;
    endfunction : reset_value

    // Register read view; both channel bits set reads channel A
    function automatic logic [7:0] read_reg(input logic [adc_cfg_pkg::ADDR_WIDTH-1:0] a);
        logic [7:0] lo;
        lo = a[7:0];
        if (a[adc_cfg_pkg::ADDR_WIDTH-1:8] != '0) begin
            return adc_cfg_pkg::RESET_ZERO;
        end
        if (in_shadow(lo)) begin
            if (chan_index[adc_cfg_pkg::CHAN_A_BIT] || !chan_index[adc_cfg_pkg::CHAN_B_BIT]) begin
                return shadow_a[shadow_index(lo)];
            end
            return shadow_b[shadow_index(lo)];
        end
        unique case (lo)
            adc_cfg_pkg::ADDR_PORT_CFG: return port_cfg;
            adc_cfg_pkg::ADDR_CHIP_ID: return CHIP_ID;
            adc_cfg_pkg::ADDR_CHIP_GRADE: return CHIP_GRADE;
            adc_cfg_pkg::ADDR_CHAN_INDEX: return {6'h00, chan_index};
            adc_cfg_pkg::ADDR_DIVIDER_ALIGN: return align_shadow;
            adc_cfg_pkg::ADDR_SHADOW_COMMIT: return {7'h00, commit};
            default: return adc_cfg_pkg::RESET_ZERO;
        endcase
    endfunction : read_reg

    // Pin retiming
    two_flop_sync #(
        .WIDTH(4)
    ) pin_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in({serial_shift_clock, select_low, serial_bidir_data_in, sync_align_input}),
        .sync_out(pins)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sclk_q <= 1'b0;
            // Matches the synchroniser's reset level, so no false select fall follows reset
            select_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            sclk_q <= pins.sclk;
            select_q <= pins.select_low;
            sync_q <= pins.sync_align;
        end
    end

    assign sclk_rise = pins.sclk && !sclk_q;
    assign sclk_fall = !pins.sclk && sclk_q;
    assign select_fall = !pins.select_low && select_q;
    assign select_rise = pins.select_low && !select_q;
    assign sync_rise = pins.sync_align && !sync_q;
    assign lsb_first = port_cfg[adc_cfg_pkg::PORT_LSB_FIRST_BIT];

    // Shift direction follows the configured bit order
    always_comb begin
        if (lsb_first) begin
            next_instr = {pins.sdio, instr[15:1]};
            next_data = {pins.sdio, data_shift[7:1]};
        end else begin
            next_instr = {instr[14:0], pins.sdio};
            next_data = {data_shift[6:0], pins.sdio};
        end
    end

    // Frame sequencing
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= adc_cfg_pkg::ST_IDLE;
            resume_state <= adc_cfg_pkg::ST_INSTR;
            bit_cnt <= 4'h0;
            instr <= 16'h0000;
            data_shift <= 8'h00;
            addr <= '0;
            is_read <= 1'b0;
            len_code <= adc_cfg_pkg::LEN_ONE;
            bytes_done <= 2'h0;
            wr_en <= 1'b0;
            wr_addr <= '0;
            wr_data <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            unique case (state)
                adc_cfg_pkg::ST_IDLE: begin
                    if (select_fall) begin
                        state <= adc_cfg_pkg::ST_INSTR;
                        bit_cnt <= 4'h0;
                    end
                end
                adc_cfg_pkg::ST_INSTR: begin
                    if (select_rise) begin
                        resume_state <= adc_cfg_pkg::ST_INSTR;
                        state <= (bit_cnt[2:0] == 3'h0) ? adc_cfg_pkg::ST_PAUSE
                                                         : adc_cfg_pkg::ST_IDLE;
                    end else if (sclk_rise) begin
                        instr <= next_instr;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == adc_cfg_pkg::INSTR_LAST_BIT) begin
                            state <= adc_cfg_pkg::ST_DATA;
                            bit_cnt <= 4'h0;
                            is_read <= next_instr[adc_cfg_pkg::INSTR_RW_BIT];
                            len_code <= next_instr[adc_cfg_pkg::INSTR_LEN_MSB:
                                                   adc_cfg_pkg::INSTR_LEN_LSB];
                            addr <= next_instr[adc_cfg_pkg::ADDR_WIDTH-1:0];
                            bytes_done <= 2'h0;
                        end
                    end
                end
                adc_cfg_pkg::ST_DATA: begin
                    if (select_rise) begin
                        resume_state <= adc_cfg_pkg::ST_DATA;
                        if (len_code == adc_cfg_pkg::LEN_STREAM || bit_cnt[2:0] != 3'h0) begin
                            state <= adc_cfg_pkg::ST_IDLE;
                        end else begin
                            state <= adc_cfg_pkg::ST_PAUSE;
                        end
                    end else if (sclk_rise) begin
                        data_shift <= next_data;
                        bit_cnt <= {1'b0, bit_cnt[2:0] + 3'h1};
                        if (bit_cnt[2:0] == adc_cfg_pkg::WORD_LAST_BIT) begin
                            bit_cnt <= 4'h0;
                            wr_en <= !is_read;
                            wr_addr <= addr;
                            wr_data <= next_data;
                            addr <= addr + {{(adc_cfg_pkg::ADDR_WIDTH-1){1'b0}}, 1'b1};
                            bytes_done <= bytes_done + 2'h1;
                            if (len_code != adc_cfg_pkg::LEN_STREAM && bytes_done == len_code) begin
                                state <= adc_cfg_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                adc_cfg_pkg::ST_PAUSE: begin
                    if (select_fall) begin
                        state <= resume_state;
                    end
                end
            endcase
        end
    end

    // Readback drive, changed on falling serial clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            read_shift <= 8'h00;
        end else if (state == adc_cfg_pkg::ST_DATA && is_read && sclk_fall) begin
            if (bit_cnt[2:0] == 3'h0) begin
                read_shift <= read_reg(addr);
            end else if (lsb_first) begin
                read_shift <= {1'b0, read_shift[7:1]};
            end else begin
                read_shift <= {read_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial_bidir_data_oe <= 1'b0;
            secondary_function_enable <= 1'b0;
        end else begin
            serial_bidir_data_oe <= state == adc_cfg_pkg::ST_DATA && is_read
                                    && !pins.select_low;
            secondary_function_enable <= pins.select_low
                                         && state != adc_cfg_pkg::ST_DATA
                                         && state != adc_cfg_pkg::ST_INSTR;
        end
    end

    assign serial_bidir_data_out = lsb_first ? read_shift[0] : read_shift[7];

    // Register file and shadow copies
    always_ff @(posedge sys_clk) begin
        if (srst || soft_reset) begin
            port_cfg <= adc_cfg_pkg::RESET_PORT_CFG;
            chan_index <= adc_cfg_pkg::RESET_CHAN_INDEX;
            commit <= 1'b0;
            soft_reset <= 1'b0;
            align_shadow <= adc_cfg_pkg::RESET_ZERO;
            for (int i = 0; i < adc_cfg_pkg::SHADOW_DEPTH; i++) begin
                shadow_a[i] <= reset_value(i);
                shadow_b[i] <= reset_value(i);
            end
        end else begin
            commit <= 1'b0;
            if (wr_en && wr_addr[adc_cfg_pkg::ADDR_WIDTH-1:8] == '0) begin
                if (in_shadow(wr_addr[7:0])) begin
                    if (chan_index[adc_cfg_pkg::CHAN_A_BIT]) begin
                        shadow_a[shadow_index(wr_addr[7:0])] <= wr_data;
                    end
                    if (chan_index[adc_cfg_pkg::CHAN_B_BIT]) begin
                        shadow_b[shadow_index(wr_addr[7:0])] <= wr_data;
                    end
                end
                unique case (wr_addr[7:0])
                    adc_cfg_pkg::ADDR_PORT_CFG: begin
                        port_cfg <= (wr_data & adc_cfg_pkg::PORT_LSB_FIRST_MASK) != 8'h00
                                    ? (adc_cfg_pkg::RESET_PORT_CFG
                                       | adc_cfg_pkg::PORT_LSB_FIRST_MASK)
                                    : adc_cfg_pkg::RESET_PORT_CFG;
                        soft_reset <= (wr_data & adc_cfg_pkg::PORT_SOFT_RESET_MASK) != 8'h00;
                    end
                    adc_cfg_pkg::ADDR_CHAN_INDEX: begin
                        chan_index <= wr_data[1:0];
                    end
                    adc_cfg_pkg::ADDR_DIVIDER_ALIGN: begin
                        align_shadow <= wr_data;
                    end
                    adc_cfg_pkg::ADDR_SHADOW_COMMIT: begin
                        commit <= wr_data[adc_cfg_pkg::COMMIT_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Active copies change only on commit, soft reset or srst
    always_ff @(posedge sys_clk) begin
        if (srst || soft_reset) begin
            divider_align_active <= adc_cfg_pkg::RESET_ZERO;
            for (int i = 0; i < adc_cfg_pkg::SHADOW_DEPTH; i++) begin
                active_a[i] <= reset_value(i);
                active_b[i] <= reset_value(i);
            end
        end else if (commit) begin
            divider_align_active <= align_shadow;
            for (int i = 0; i < adc_cfg_pkg::SHADOW_DEPTH; i++) begin
                active_a[i] <= shadow_a[i];
                active_b[i] <= shadow_b[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            output_format_a <= adc_cfg_pkg::RESET_OUTPUT_FORMAT;
            output_format_b <= adc_cfg_pkg::RESET_OUTPUT_FORMAT;
        end else begin
            output_format_a <= active_a[shadow_index(adc_cfg_pkg::ADDR_OUTPUT_FORMAT)];
            output_format_b <= active_b[shadow_index(adc_cfg_pkg::ADDR_OUTPUT_FORMAT)];
        end
    end

    // Clock divider with sync realignment
    assign div_ratio = active_a[shadow_index(adc_cfg_pkg::ADDR_CLOCK_DIVIDE)]
                       [adc_cfg_pkg::DIVIDE_RATIO_MSB:adc_cfg_pkg::DIVIDE_RATIO_LSB];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_count <= 3'h0;
            divider_tick <= 1'b0;
            aligned_once <= 1'b0;
        end else begin
            divider_tick <= div_count == div_ratio;
            div_count <= (div_count >= div_ratio) ? 3'h0 : div_count + 3'h1;
            if (!divider_align_active[adc_cfg_pkg::ALIGN_ENABLE_BIT]) begin
                aligned_once <= 1'b0;
            end else if (sync_rise && !(aligned_once
                         && divider_align_active[adc_cfg_pkg::ALIGN_ONESHOT_BIT])) begin
                div_count <= 3'h0;
                aligned_once <= 1'b1;
            end
        end
    end
endmodule : adc_config_serial_port
`default_nettype wire

/* dv/adc_cfg_chk.sv */
// Checker for the configuration serial port: pin direction, select gating, active copies.
// Assumes it is bound to adc_config_serial_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Serial pins and divider
    input wire logic serial_shift_clock,
    input wire logic select_low,
    input wire logic serial_bidir_data_in,
    input wire logic serial_bidir_data_out,
    input wire logic serial_bidir_data_oe,
    input wire logic secondary_function_enable,
    input wire logic sync_align_input,
    input wire logic divider_tick,
    // Active configuration
    input wire logic [7:0] output_format_a,
    input wire logic [7:0] output_format_b,
    input wire logic [7:0] divider_align_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_oe_select_high: assert property (select_low [*8] |-> !serial_bidir_data_oe)
        else $error("data pin driven with select high");
    a_oe_release: assert property ($rose(select_low) |-> ##[1:6] !serial_bidir_data_oe)
        else $error("data pin not released after select rose");
    a_oe_in_frame: assert property ($rose(serial_bidir_data_oe) |-> !select_low)
        else $error("data pin turned around outside a frame");
    a_secondary_on: assert property (select_low [*8] |-> secondary_function_enable)
        else $error("secondary function off with select high");
    a_secondary_off: assert property (!select_low [*6] |-> !secondary_function_enable)
        else $error("secondary function on with select low");
    a_data_on_fall: assert property (serial_bidir_data_oe && $changed(serial_bidir_data_out)
        |-> !serial_shift_clock)
        else $error("read data changed while serial clock high");
    a_active_quiet: assert property (select_low [*8] |=> $stable(output_format_a)
        && $stable(output_format_b) && $stable(divider_align_active))
        else $error("active configuration changed with port idle");
    a_reset_values: assert property ($fell(srst) |-> output_format_a == 8'h05
        && output_format_b == 8'h05 && divider_align_active == 8'h00)
        else $error("active configuration not at defaults after reset");
    c_read_turn: cover property ($rose(serial_bidir_data_oe));
    c_commit: cover property ($changed(output_format_a));
    c_tick: cover property (divider_tick);
endmodule : adc_cfg_chk
`default_nettype wire

/* dv/spi_master_model.sv */
// Serial port master model: drives clock, select and data, resolves the shared data wire.
// Assumes sys_clk pacing; the serial clock idles low and runs only inside frames.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model #(
    parameter int HALF = 8
) (
    // Clock
    input wire logic sys_clk,
    // Pins toward the device
    output logic sclk,
    output logic select_low,
    output logic data_wire,
    input wire logic dev_data,
    input wire logic dev_oe
);
    logic drv = 1'b0;
    logic d = 1'b0;
    logic lsb_first = 1'b0;
    initial begin
        sclk = 1'b0;
        select_low = 1'b1;
    end
    // A released wire shows the inverse of the last driven bit
    assign data_wire = dev_oe ? dev_data : (drv ? d : ~d);
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic bits(input logic [15:0] v, input int n, input logic rd, output logic [15:0] g);
        int j;
        g = 16'h0000;
        for (int i = 0; i < n; i++) begin
            j = lsb_first ? i : n - 1 - i;
            d = v[j];
            drv = ~rd;
            wt(HALF);
            sclk = 1'b1;
            g[j] = data_wire;
            wt(HALF);
            sclk = 1'b0;
        end
    endtask : bits
    task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] a,
            input int nb, input logic [23:0] wd, input logic pause, output logic [23:0] q);
        logic [15:0] g;
        q = 24'h000000;
        select_low = 1'b0;
        wt(HALF);
        bits({rd, len, a}, 16, 1'b0, g);
        for (int k = 0; k < nb; k++) begin
            if (pause) begin
                drv = 1'b0;
                select_low = 1'b1;
                wt(2 * HALF);
                select_low = 1'b0;
                wt(HALF);
            end
            bits({8'h00, wd[8*k +: 8]}, 8, rd, g);
            q[8*k +: 8] = g[7:0];
        end
        drv = 1'b0;
        wt(HALF);
        select_low = 1'b1;
        wt(2 * HALF);
    endtask : xfer
endmodule : spi_master_model
`default_nettype wire

/* dv/tb.sv */
// Testbench: register frames through the master model, checks readback and active copies.
// Assumes the master model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic sync_in = 1'b0;
    logic sclk, sel_low, data_wire, dout, doe, sec_en, tick;
    logic [7:0] fmt_a, fmt_b, align, v, v2;
    logic [12:0] a;
    logic [23:0] q;
    int fail_count = 0;
    int tests_run = 0;
    int n;
    integer seed = 32'h942D4E92;
    always #20 sys_clk = ~sys_clk;
    spi_master_model #(.HALF(8)) m (.sys_clk(sys_clk), .sclk(sclk), .select_low(sel_low),
        .data_wire(data_wire), .dev_data(dout), .dev_oe(doe));
    adc_config_serial_port DUT (.sys_clk(sys_clk), .srst(srst), .serial_shift_clock(sclk),
        .select_low(sel_low), .serial_bidir_data_in(data_wire), .serial_bidir_data_out(dout),
        .serial_bidir_data_oe(doe), .secondary_function_enable(sec_en),
        .sync_align_input(sync_in), .divider_tick(tick), .output_format_a(fmt_a),
        .output_format_b(fmt_b), .divider_align_active(align));
    // Sync moves just after a clock edge, as a source on the converter clock would
    always @(posedge sys_clk) begin
        #1;
        sync_in = 1'($random(seed));
    end
    // Register contents after reset; id uses the arbitrary default
    function automatic logic [7:0] rst_val(input logic [12:0] ad);
        case (ad)
            13'h0000: return 8'h18;
            13'h0001: return 8'h5A;
            13'h0005: return 8'h03;
            13'h0014: return 8'h05;
            default: return 8'h00;
        endcase
    endfunction : rst_val
    function automatic logic [23:0] exp_rd(input logic [12:0] ad, input int nb);
        logic [23:0] e;
        e = 24'h000000;
        for (int k = 0; k < nb; k++) e[8*k +: 8] = rst_val(ad + 13'(k));
        return e;
    endfunction : exp_rd
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [12:0] ad, input logic [7:0] d, input logic p);
        m.xfer(1'b0, 2'h0, ad, 1, {16'h0000, d}, p, q);
    endtask : wr
    task automatic rd(input logic [12:0] ad, input logic [1:0] len, input logic p);
        m.xfer(1'b1, len, ad, len == 2'h3 ? 3 : int'(len) + 1, 24'h000000, p, q);
    endtask : rd
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        chk("fmt_a", 24'h5, {16'h0000, fmt_a});
        chk("sec", 24'h1, {23'h0, sec_en});
        for (int L = 0; L < 4; L++) begin
            a = (L == 3) ? 13'h0003 : 13'h0000;
            rd(a, 2'(L), L == 2);
            chk("rd_rst", exp_rd(a, L == 3 ? 3 : L + 1), q);
        end
        rd(13'h1014, 2'h0, 1'b0);
        chk("unmapped", 24'h0, q);
        v = 8'($random(seed));
        v2 = 8'($random(seed));
        wr(13'h0014, v, 1'b1);
        chk("shadow", 24'h5, {16'h0000, fmt_a});
        rd(13'h0014, 2'h0, 1'b0);
        chk("rd_shadow", {16'h0000, v}, q);
        wr(13'h00FF, 8'h01, 1'b0);
        chk("fmt_a", {16'h0000, v}, {16'h0000, fmt_a});
        chk("fmt_b", {16'h0000, v}, {16'h0000, fmt_b});
        rd(13'h00FF, 2'h0, 1'b0);
        chk("commit_clr", 24'h0, q);
        wr(13'h0005, 8'h01, 1'b0);
        wr(13'h0014, v2, 1'b0);
        wr(13'h003A, 8'h06, 1'b0);
        wr(13'h000B, 8'h03, 1'b0);
        chk("align_shadow", 24'h0, {16'h0000, align});
        wr(13'h00FF, 8'h01, 1'b0);
        chk("fmt_a2", {16'h0000, v2}, {16'h0000, fmt_a});
        chk("fmt_b2", {16'h0000, v}, {16'h0000, fmt_b});
        chk("align", 24'h6, {16'h0000, align});
        // One-shot realign has happened by now; ratio 3 gives a tick every fourth cycle
        repeat (20) @(posedge sys_clk);
        n = 0;
        repeat (40) begin
            @(posedge sys_clk);
            #1;
            n += int'(tick);
        end
        chk("ticks", 24'h00000A, 24'(n));
        wr(13'h0005, 8'h03, 1'b0);
        wr(13'h0000, 8'h42, 1'b0);
        m.lsb_first = 1'b1;
        rd(13'h0014, 2'h0, 1'b0);
        chk("lsb_rd", {16'h0000, v2}, q);
        wr(13'h0000, 8'h24, 1'b0);
        m.lsb_first = 1'b0;
        chk("soft_rst", 24'h5, {16'h0000, fmt_a});
        rd(13'h0000, 2'h0, 1'b0);
        chk("port_cfg", 24'h18, q);
        give_verdict();
    end
endmodule : tb
bind adc_config_serial_port adc_cfg_chk chk_i (.sys_clk(sys_clk), .srst(srst),
    .serial_shift_clock(serial_shift_clock), .select_low(select_low),
    .serial_bidir_data_in(serial_bidir_data_in), .serial_bidir_data_out(serial_bidir_data_out),
    .serial_bidir_data_oe(serial_bidir_data_oe),
    .secondary_function_enable(secondary_function_enable),
    .sync_align_input(sync_align_input), .divider_tick(divider_tick),
    .output_format_a(output_format_a), .output_format_b(output_format_b),
    .divider_align_active(divider_align_active));
`default_nettype wire
